/* File: logic/pcrb_cal_seq.sv */
// calibration sequencer: runs a calibration and latches the bandwidth
`timescale 1ns/1ps
`default_nettype none
module pcrb_cal_seq
    import pcrb_pkg::*;
#(
    parameter int CAL_CYCLES = 16
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       calStart,
    input  wire logic [3:0] bwWritten,
    output logic            calBusy,
    output logic            calDone,
    output logic [3:0]      bwApplied
);
    typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_FIN} pcrb_cal_t;

    localparam int CNT_W = $clog2(CAL_CYCLES + 1);

    pcrb_cal_t        state_reg;
    pcrb_cal_t        state_next;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [3:0]       bw_reg;
    logic             done_reg;
    wire              countEnd = (count_reg == CNT_W'(CAL_CYCLES - 1));

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            CAL_IDLE: begin
                count_next = '0;
                if (calStart) begin
                    state_next = CAL_RUN;
                end
            end
            CAL_RUN: begin
                count_next = count_reg + CNT_W'(1);
                if (countEnd) begin
                    state_next = CAL_FIN;
                end
            end
            CAL_FIN: begin
                state_next = CAL_IDLE;
            end
            default: begin
                state_next = CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_reg <= CAL_IDLE;
            count_reg <= '0;
            bw_reg    <= RST_BW_RANGE[BW_LSB +: 4];
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            // new bandwidth only takes effect at calibration end
            if (state_reg == CAL_FIN) begin
                bw_reg <= bwWritten;
            end
            if (state_reg == CAL_FIN) begin
                done_reg <= 1'b1;
            end else if (calStart && state_reg == CAL_IDLE) begin
                done_reg <= 1'b0;
            end
        end
    end

    assign calBusy   = (state_reg != CAL_IDLE);
    assign calDone   = done_reg;
    assign bwApplied = bw_reg;
endmodule // pcrb_cal_seq
`default_nettype wire

/* File: logic/pcrb_cfg_reg.sv */
// one configuration byte with per-bit write mask and fixed bits
`timescale 1ns/1ps
`default_nettype none
module pcrb_cfg_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK   = 8'hFF
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrData,
    output logic      [7:0] value
);
    logic [7:0] value_reg;
    logic [7:0] value_next;

    // read-only bits keep the reset value whatever is written
    assign value_next = (wrData & WR_MASK) | (RESET_VAL & ~WR_MASK);
    assign value      = value_reg;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            value_reg <= RESET_VAL;
        end else if (wrEn) begin
            value_reg <= value_next;
        end
    end
endmodule // pcrb_cfg_reg
`default_nettype wire

/* File: logic/pcrb_pkg.sv */
// package of register map constants for the loop configuration bank
package pcrb_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 8;
    // five-bit bus address prefix and loop selector width
    localparam logic [4:0]  BUS_ADDR_PREFIX  = 5'h1A;
    localparam int          LOOP_SEL_W       = 2;

    localparam logic [7:0]  OFS_LOOP_MODE    = 8'h00;
    localparam logic [7:0]  OFS_BW_RANGE     = 8'h02;
    localparam logic [7:0]  OFS_FREEZE_MUTE  = 8'h03;
    localparam logic [7:0]  OFS_CMOS_DRIVE   = 8'h05;
    localparam logic [7:0]  OFS_OUT_FORMAT   = 8'h06;

    localparam logic [7:0]  RST_LOOP_MODE    = 8'h14;
    localparam logic [7:0]  RST_BW_RANGE     = 8'h42;
    localparam logic [7:0]  RST_FREEZE_MUTE  = 8'h05;
    localparam logic [7:0]  RST_CMOS_DRIVE   = 8'hED;
    localparam logic [7:0]  RST_OUT_FORMAT   = 8'h2D;

    // writable bit masks
    localparam logic [7:0]  WM_LOOP_MODE     = 8'h62;
    localparam logic [7:0]  WM_BW_RANGE      = 8'hFF;
    localparam logic [7:0]  WM_FREEZE_MUTE   = 8'h30;
    localparam logic [7:0]  WM_CMOS_DRIVE    = 8'hC0;
    localparam logic [7:0]  WM_OUT_FORMAT    = 8'h07;

    localparam int          BIT_FREE_RUN     = 6;
    localparam int          BIT_UNSQUELCH    = 5;
    localparam int          BIT_PASSTHROUGH  = 1;
    localparam int          BIT_HOLD_FORCE   = 5;
    localparam int          BIT_CAL_MUTE     = 4;
    localparam int          BW_LSB           = 4;
    localparam int          RANGE_LSB        = 0;
    localparam int          DRIVE_LSB        = 6;
    localparam int          FMT_LSB          = 0;

    localparam logic [3:0]  RANGE_LOW        = 4'h5;
    localparam logic [3:0]  RANGE_HIGH       = 4'h6;

    typedef enum logic [2:0] {
        PCRB_FMT_RSV0    = 3'h0,
        PCRB_FMT_DISABLE = 3'h1,
        PCRB_FMT_CMOS    = 3'h2,
        PCRB_FMT_LSLVDS  = 3'h3,
        PCRB_FMT_RSV4    = 3'h4,
        PCRB_FMT_LVPECL  = 3'h5,
        PCRB_FMT_CML     = 3'h6,
        PCRB_FMT_LVDS    = 3'h7
    } pcrb_fmt_t;
endpackage : pcrb_pkg

/* File: logic/pll_config_register_bank.sv */
// per-loop configuration register bank of a multi-loop clock multiplier
// Behaviour
// - free run routes reference oscillator into loop
// - output squelched until calibrated unless override
// - passthrough connects input clock to outputs
// - bandwidth applies only after a calibration
// - hold force overrides all input selection
// - calibration mute disables outputs during calibration unless override
// - drive code selects 8 to 32 mA
// - format field selects output buffer mode
// - loop mode register resets to 0x14
// - each loop has own map at 11010xx
`timescale 1ns/1ps
`default_nettype none
module pll_config_register_bank
    import pcrb_pkg::*;
#(
    parameter logic [1:0] LOOP_ID    = 2'h0,
    parameter int         CAL_CYCLES = 16
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic [6:0]        busDevAddr,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    input  wire logic [DATA_W-1:0] regWrData,
    output logic      [DATA_W-1:0] regRdData,
    output logic                   regRdValid,
    output logic                   regAddrErr,
    input  wire logic              calStart,
    input  wire logic              loopInHold,
    output logic                   calBusy,
    output logic                   calDone,
    output logic                   refToLoop,
    output logic                   loopBypass,
    output logic                   holdForce,
    output logic                   clockOutputEnable,
    output logic [3:0]             loopBwApplied,
    output logic [3:0]             refRange,
    output logic                   refRangeValid,
    output logic [1:0]             cmosDriveSel,
    output logic [5:0]             cmosDriveMa,
    output logic [2:0]             outputFormat,
    output logic                   outputDisabled,
    output logic                   formatReserved,
    output logic                   bypassCmosConflict,
    output logic                   bypassMisuse
);
    // selection of this loop's map by the bus address
    wire        selLoop  = (busDevAddr == {BUS_ADDR_PREFIX, LOOP_ID});
    wire        hitMode  = (regAddr == OFS_LOOP_MODE);
    wire        hitBw    = (regAddr == OFS_BW_RANGE);
    wire        hitFrz   = (regAddr == OFS_FREEZE_MUTE);
    wire        hitDrv   = (regAddr == OFS_CMOS_DRIVE);
    wire        hitFmt   = (regAddr == OFS_OUT_FORMAT);
    wire        hitAny   = hitMode | hitBw | hitFrz | hitDrv | hitFmt;
    wire        wrOk     = selLoop & regWrite;

    logic [7:0] modeVal;
    logic [7:0] bwVal;
    logic [7:0] frzVal;
    logic [7:0] drvVal;
    logic [7:0] fmtVal;
    logic       calBusyInt;
    logic       calDoneInt;
    logic [3:0] bwAppliedInt;
    logic       calSeen_reg;

    // loop mode register resets to 0x14
    pcrb_cfg_reg #(
        .RESET_VAL (RST_LOOP_MODE),
        .WR_MASK   (WM_LOOP_MODE)
    ) u_mode (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wrEn     (wrOk & hitMode),
        .wrData   (regWrData),
        .value    (modeVal)
    );

    pcrb_cfg_reg #(
        .RESET_VAL (RST_BW_RANGE),
        .WR_MASK   (WM_BW_RANGE)
    ) u_bw (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wrEn     (wrOk & hitBw),
        .wrData   (regWrData),
        .value    (bwVal)
    );

    pcrb_cfg_reg #(
        .RESET_VAL (RST_FREEZE_MUTE),
        .WR_MASK   (WM_FREEZE_MUTE)
    ) u_frz (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wrEn     (wrOk & hitFrz),
        .wrData   (regWrData),
        .value    (frzVal)
    );

    pcrb_cfg_reg #(
        .RESET_VAL (RST_CMOS_DRIVE),
        .WR_MASK   (WM_CMOS_DRIVE)
    ) u_drv (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wrEn     (wrOk & hitDrv),
        .wrData   (regWrData),
        .value    (drvVal)
    );

    pcrb_cfg_reg #(
        .RESET_VAL (RST_OUT_FORMAT),
        .WR_MASK   (WM_OUT_FORMAT)
    ) u_fmt (
        .core_clk (core_clk),
        .nrst     (nrst),
        .wrEn     (wrOk & hitFmt),
        .wrData   (regWrData),
        .value    (fmtVal)
    );

    pcrb_cal_seq #(
        .CAL_CYCLES (CAL_CYCLES)
    ) u_cal (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .calStart  (calStart),
        .bwWritten (bwVal[BW_LSB +: 4]),
        .calBusy   (calBusyInt),
        .calDone   (calDoneInt),
        .bwApplied (bwAppliedInt)
    );

    // read mux
    logic [7:0] rdMux;
    always_comb begin
        rdMux = 8'h00;
        if (hitMode) rdMux = modeVal;
        if (hitBw)   rdMux = bwVal;
        if (hitFrz)  rdMux = frzVal;
        if (hitDrv)  rdMux = drvVal;
        if (hitFmt)  rdMux = fmtVal;
    end

    // field decode
    wire        freeRunBit   = modeVal[BIT_FREE_RUN];
    wire        unsquelchBit = modeVal[BIT_UNSQUELCH];
    wire        passBit      = modeVal[BIT_PASSTHROUGH];
    wire        holdBit      = frzVal[BIT_HOLD_FORCE];
    wire        calMuteBit   = frzVal[BIT_CAL_MUTE];
    wire [1:0]  driveCode    = drvVal[DRIVE_LSB +: 2];
    wire [2:0]  fmtCode      = fmtVal[FMT_LSB +: 3];
    wire [3:0]  rangeCode    = bwVal[RANGE_LSB +: 4];
    wire        fmtIsCmos    = (fmtCode == PCRB_FMT_CMOS);
    wire        fmtIsRsv     = (fmtCode == PCRB_FMT_RSV0)
                             | (fmtCode == PCRB_FMT_RSV4);
    wire        fmtIsOff     = (fmtCode == PCRB_FMT_DISABLE);

    // sticky: a later calibration clears calDone, yet the output must
    // not fall back to the squelch meant for an uncalibrated part
    wire        calSeen       = calSeen_reg | calDoneInt;
    // squelch: before first calibration unless overridden, and during
    // calibration when mute is on and not overridden
    wire        preCalSquelch = ~calSeen & ~unsquelchBit;
    wire        muteSquelch   = calBusyInt & calMuteBit
                              & ~unsquelchBit;
    wire        outEnNext     = ~preCalSquelch & ~muteSquelch
                              & ~fmtIsOff & ~fmtIsRsv;

    // 8 mA steps: (code + 1) * 8
    wire [5:0]  driveMaNext   = fmtIsCmos
                              ? {1'b0, driveCode, 3'h0} + 6'h08
                              : 6'h00;

    wire        rangeOk       = (rangeCode == RANGE_LOW)
                              | (rangeCode == RANGE_HIGH);
    // flag host misuse; the device does not police these
    wire        conflictNext  = passBit & fmtIsCmos;
    wire        misuseNext    = passBit & ~loopInHold
                              & calSeen;

    logic [7:0] rdData_reg;
    logic       rdValid_reg;
    logic       addrErr_reg;
    logic       refToLoop_reg;
    logic       bypass_reg;
    logic       hold_reg;
    logic       outEn_reg;
    logic [3:0] bw_reg;
    logic [3:0] range_reg;
    logic       rangeOk_reg;
    logic [1:0] drive_reg;
    logic [5:0] driveMa_reg;
    logic [2:0] fmt_reg;
    logic       fmtOff_reg;
    logic       fmtRsv_reg;
    logic       conflict_reg;
    logic       misuse_reg;
    logic       busy_reg;
    logic       done_reg;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdData_reg  <= 8'h00;
            rdValid_reg <= 1'b0;
            addrErr_reg <= 1'b0;
        end else begin
            rdValid_reg <= selLoop & regRead;
            addrErr_reg <= selLoop & (regRead | regWrite) & ~hitAny;
            if (selLoop & regRead) begin
                rdData_reg <= rdMux;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            refToLoop_reg <= 1'b0;
            bypass_reg    <= 1'b0;
            hold_reg      <= 1'b0;
            outEn_reg     <= 1'b0;
        end else begin
            refToLoop_reg <= freeRunBit;
            bypass_reg    <= passBit;
            hold_reg      <= holdBit;
            outEn_reg     <= outEnNext;
        end
    end

    // calibration results; calSeen_reg only clears on reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bw_reg        <= RST_BW_RANGE[BW_LSB +: 4];
            busy_reg      <= 1'b0;
            done_reg      <= 1'b0;
            calSeen_reg   <= 1'b0;
        end else begin
            bw_reg        <= bwAppliedInt;
            busy_reg      <= calBusyInt;
            done_reg      <= calDoneInt;
            calSeen_reg   <= calSeen;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            range_reg     <= RST_BW_RANGE[RANGE_LSB +: 4];
            rangeOk_reg   <= 1'b0;
            drive_reg     <= RST_CMOS_DRIVE[DRIVE_LSB +: 2];
            driveMa_reg   <= 6'h00;
        end else begin
            range_reg     <= rangeCode;
            rangeOk_reg   <= rangeOk;
            drive_reg     <= driveCode;
            driveMa_reg   <= driveMaNext;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fmt_reg       <= RST_OUT_FORMAT[FMT_LSB +: 3];
            fmtOff_reg    <= 1'b0;
            fmtRsv_reg    <= 1'b0;
            conflict_reg  <= 1'b0;
            misuse_reg    <= 1'b0;
        end else begin
            fmt_reg       <= fmtCode;
            fmtOff_reg    <= fmtIsOff;
            fmtRsv_reg    <= fmtIsRsv;
            conflict_reg  <= conflictNext;
            misuse_reg    <= misuseNext;
        end
    end

    assign regRdData          = rdData_reg;
    assign regRdValid         = rdValid_reg;
    assign regAddrErr         = addrErr_reg;
    assign refToLoop          = refToLoop_reg;
    assign loopBypass         = bypass_reg;
    assign holdForce          = hold_reg;
    assign clockOutputEnable  = outEn_reg;
    assign loopBwApplied      = bw_reg;
    assign refRange           = range_reg;
    assign refRangeValid      = rangeOk_reg;
    assign cmosDriveSel       = drive_reg;
    assign cmosDriveMa        = driveMa_reg;
    assign outputFormat       = fmt_reg;
    assign outputDisabled     = fmtOff_reg;
    assign formatReserved     = fmtRsv_reg;
    assign bypassCmosConflict = conflict_reg;
    assign bypassMisuse       = misuse_reg;
    assign calBusy            = busy_reg;
    assign calDone            = done_reg;
endmodule // pll_config_register_bank
`default_nettype wire

/* File: verification/pcrb_checker_sva.sv */
// assertion checker for the loop configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module pcrb_checker
    import pcrb_pkg::*;
#(
    parameter logic [1:0] LOOP_ID = 2'h0
) (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic [6:0] busDevAddr,
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic       regRdValid,
    input wire logic       regAddrErr,
    input wire logic       calDone,
    input wire logic       refToLoop,
    input wire logic       loopBypass,
    input wire logic       holdForce,
    input wire logic [3:0] loopBwApplied,
    input wire logic [1:0] cmosDriveSel,
    input wire logic [5:0] cmosDriveMa,
    input wire logic [2:0] outputFormat,
    input wire logic       outputDisabled,
    input wire logic       formatReserved
);
    logic hit;
    logic acc;
    logic mapped;
    assign hit    = busDevAddr == {BUS_ADDR_PREFIX, LOOP_ID};
    assign acc    = (regRead || regWrite) && hit;
    assign mapped = regAddr == OFS_LOOP_MODE || regAddr == OFS_BW_RANGE
                 || regAddr == OFS_FREEZE_MUTE || regAddr == OFS_CMOS_DRIVE
                 || regAddr == OFS_OUT_FORMAT;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // a write to one offset not overwritten on the next cycle
    sequence wr_s(logic [7:0] a);
        regWrite && hit && regAddr == a ##1 !(regWrite && hit && regAddr == a);
    endsequence
    property bit_p(logic [7:0] a, int b, logic o);
        wr_s(a) |=> o == $past(regWrData[b], 2);
    endproperty
    rd_answer_a:
    assert property (regRead && hit && mapped |=> regRdValid && !regAddrErr)
        else $error("mapped read not answered");
    other_loop_a:
    assert property ((regRead || regWrite) && !hit
                     |=> !regRdValid && !regAddrErr)
        else $error("foreign access answered");
    hole_err_a:
    assert property (acc && !mapped |=> regAddrErr)
        else $error("unmapped access without error pulse");
    hole_data_a:
    assert property (regRead && hit && !mapped |=> regRdData == 8'h00)
        else $error("unmapped read data not zero");
    free_run_a:
    assert property (bit_p(OFS_LOOP_MODE, BIT_FREE_RUN, refToLoop))
        else $error("reference route does not follow its bit");
    loop_bypass_a:
    assert property (bit_p(OFS_LOOP_MODE, BIT_PASSTHROUGH, loopBypass))
        else $error("bypass does not follow its bit");
    hold_force_a:
    assert property (bit_p(OFS_FREEZE_MUTE, BIT_HOLD_FORCE, holdForce))
        else $error("hold force does not follow its bit");
    drive_ma_a:
    assert property (cmosDriveMa == (outputFormat == 3'h2 ?
                     6'h08 * ({4'h0, cmosDriveSel} + 6'h01) : 6'h00))
        else $error("drive current wrong");
    fmt_decode_a:
    assert property (outputDisabled == (outputFormat == 3'h1) && formatReserved
                     == (outputFormat == 3'h0 || outputFormat == 3'h4))
        else $error("format decode wrong");
    bw_apply_a:
    assert property ($changed(loopBwApplied) |-> $rose(calDone))
        else $error("bandwidth changed without calibration");
endmodule // pcrb_checker
bind pll_config_register_bank pcrb_checker #(.LOOP_ID(LOOP_ID)) chk_u (
    .core_clk, .nrst, .busDevAddr, .regAddr, .regWrite, .regRead,
    .regWrData, .regRdData, .regRdValid, .regAddrErr, .calDone,
    .refToLoop, .loopBypass, .holdForce, .loopBwApplied, .cmosDriveSel,
    .cmosDriveMa, .outputFormat, .outputDisabled, .formatReserved
);
`default_nettype wire

/* File: verification/pcrb_host_model.sv */
// host model driving the register bus of the loop bank
`timescale 1ns/1ps
`default_nettype none
module pcrb_host_model
    import pcrb_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic [7:0] regRdData,
    output logic      [6:0] busDevAddr,
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regWrData
);
    initial begin
        busDevAddr = 7'h00;
        regAddr    = 8'h00;
        regWrite   = 1'b0;
        regRead    = 1'b0;
        regWrData  = 8'h00;
    end
    // one strobe cycle; released qualifiers turn over so stale values show
    task automatic xfer(input logic [1:0] loop, input logic [7:0] a,
                        input logic [7:0] d, input logic wr,
                        output logic [7:0] q);
        @(negedge core_clk);
        busDevAddr = {BUS_ADDR_PREFIX, loop};
        regAddr    = a;
        regWrData  = d;
        regWrite   = wr;
        regRead    = ~wr;
        @(negedge core_clk);
        regWrite   = 1'b0;
        regRead    = 1'b0;
        regAddr    = ~regAddr;
        regWrData  = ~regWrData;
        q          = regRdData;
    endtask
endmodule // pcrb_host_model
`default_nettype wire

/* File: verification/test_pll_config_register_bank.sv */
// self-checking bench for the loop configuration register bank
`timescale 1ns/1ps
`default_nettype none
module test_pll_config_register_bank
    import pcrb_pkg::*;
;
    localparam logic [1:0] LOOP = 2'h2;
    logic       core_clk, nrst, calStart, loopInHold, regWrite, regRead;
    logic       regRdValid, regAddrErr, calBusy, calDone, refToLoop;
    logic       loopBypass, holdForce, clockOutputEnable, refRangeValid;
    logic       outputDisabled, formatReserved, bypassCmosConflict;
    logic       bypassMisuse;
    logic [6:0] busDevAddr;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [3:0] loopBwApplied, refRange;
    logic [1:0] cmosDriveSel;
    logic [5:0] cmosDriveMa;
    logic [2:0] outputFormat;
    int         failures = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    logic [7:0] ofs [5] = '{8'h00, 8'h02, 8'h03, 8'h05, 8'h06};
    logic [7:0] rv  [5] = '{8'h14, 8'h42, 8'h05, 8'hED, 8'h2D};
    logic [7:0] ro1 [5] = '{8'h76, 8'hFF, 8'h35, 8'hED, 8'h2F};
    logic [7:0] ro0 [5] = '{8'h14, 8'h00, 8'h05, 8'h2D, 8'h28};

    pll_config_register_bank #(.LOOP_ID(LOOP), .CAL_CYCLES(2)) dut_u (
        .core_clk, .nrst, .busDevAddr, .regAddr, .regWrite, .regRead,
        .regWrData, .regRdData, .regRdValid, .regAddrErr, .calStart,
        .loopInHold, .calBusy, .calDone, .refToLoop, .loopBypass, .holdForce,
        .clockOutputEnable, .loopBwApplied, .refRange, .refRangeValid,
        .cmosDriveSel, .cmosDriveMa, .outputFormat, .outputDisabled,
        .formatReserved, .bypassCmosConflict, .bypassMisuse);
    pcrb_host_model host_u (.core_clk, .regRdData, .busDevAddr, .regAddr,
        .regWrite, .regRead, .regWrData);

    function automatic logic [7:0] b(input logic x);
        return {7'h00, x};
    endfunction
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host_u.xfer(LOOP, a, d, 1'b1, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        host_u.xfer(LOOP, a, 8'h00, 1'b0, q);
    endtask
    // derived outputs trail a write by two edges
    task automatic settle;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic cal(output logic en);
        int n;
        @(negedge core_clk);
        calStart = 1'b1;
        @(negedge core_clk);
        calStart = 1'b0;
        for (n = 0; n < 10 && calBusy !== 1'b1; n++) @(negedge core_clk);
        chk("calBusy", 8'h01, b(calBusy));
        @(negedge core_clk);
        en = clockOutputEnable;
        for (n = 0; n < 20 && calDone !== 1'b1; n++) @(negedge core_clk);
        chk("calDone", 8'h01, b(calDone));
    endtask

    task automatic t_reset;
        logic [7:0] q;
        chk("out off", 8'h00, b(clockOutputEnable));
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i], q);
            chk("reset", rv[i], q);
        end
        $display("reset values done");
    endtask
    task automatic t_ro;
        logic [7:0] q;
        // bypass set here lies before any calibration
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 8'hFF);
            rd(ofs[i], q);
            chk("ones", ro1[i], q);
        end
        settle();
        chk("refToLoop", 8'h01, b(refToLoop));
        chk("loopBypass", 8'h01, b(loopBypass));
        chk("holdForce", 8'h01, b(holdForce));
        chk("range", 8'h0F, {4'h0, refRange});
        chk("range ok", 8'h00, b(refRangeValid));
        chk("misuse", 8'h00, b(bypassMisuse));
        chk("conflict", 8'h00, b(bypassCmosConflict));
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 8'h00);
            rd(ofs[i], q);
            chk("zeros", ro0[i], q);
            wr(ofs[i], rv[i]);
        end
        settle();
        chk("loopBypass", 8'h00, b(loopBypass));
        $display("access kinds done");
    endtask
    task automatic t_fmt;
        logic [2:0] c;
        logic       r;
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            r = c == 3'h0 || c == 3'h4;
            wr(OFS_OUT_FORMAT, {5'h05, c});
            settle();
            chk("disabled", b(c == 3'h1), b(outputDisabled));
            chk("reserved", b(r), b(formatReserved));
            chk("drive", c == 3'h2 ? 8'h20 : 8'h00,
                {2'h0, cmosDriveMa});
        end
        // bypass is off while the output is CMOS
        wr(OFS_OUT_FORMAT, 8'h2A);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CMOS_DRIVE, {2'(k), 6'h2D});
            settle();
            chk("drive", 8'(8 * (k + 1)), {2'h0, cmosDriveMa});
        end
        wr(OFS_OUT_FORMAT, 8'h2D);
        $display("output format done");
    endtask
    task automatic t_bw;
        logic en;
        wr(OFS_BW_RANGE, 8'h96);
        settle();
        chk("bw held", 8'h04, {4'h0, loopBwApplied});
        chk("range", 8'h06, {4'h0, refRange});
        chk("range ok", 8'h01, b(refRangeValid));
        cal(en);
        chk("bw new", 8'h09, {4'h0, loopBwApplied});
        settle();
        chk("out on", 8'h01, b(clockOutputEnable));
        $display("bandwidth done");
    endtask
    task automatic t_mute;
        logic en;
        wr(OFS_FREEZE_MUTE, 8'h15);
        cal(en);
        chk("muted", 8'h00, b(en));
        wr(OFS_LOOP_MODE, 8'h34);
        cal(en);
        chk("unmuted", 8'h01, b(en));
        wr(OFS_LOOP_MODE, 8'h14);
        wr(OFS_FREEZE_MUTE, 8'h05);
        cal(en);
        chk("kept on", 8'h01, b(en));
        $display("calibration mute done");
    endtask
    task automatic t_addr;
        logic [7:0] q;
        rd(8'h01, q);
        chk("err", 8'h01, b(regAddrErr));
        chk("hole", 8'h00, q);
        host_u.xfer(2'h1, OFS_BW_RANGE, 8'h00, 1'b1, q);
        host_u.xfer(2'h1, OFS_BW_RANGE, 8'h00, 1'b0, q);
        chk("foreign", 8'h00, {6'h00, regRdValid, regAddrErr});
        rd(OFS_BW_RANGE, q);
        chk("kept", 8'h96, q);
        $display("addressing done");
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        nrst = 1'b0;
        calStart = 1'b0;
        loopInHold = 1'b0;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        t_reset();
        t_ro();
        t_fmt();
        t_bw();
        t_mute();
        t_addr();
        summarize();
    end
endmodule // test_pll_config_register_bank
`default_nettype wire
